// File: core/mqfb_flag_pipe.sv
// Two-stage flag register pipe with a middle tap
`timescale 1ns/1ps
module mqfb_flag_pipe #(
  parameter int W = 8,
  parameter logic [W-1:0] RST_VAL = '1
) (
  // Clock, reset, enable
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  // Flag in and out
  input wire logic [W-1:0] flag_in,
  output logic [W-1:0] flag_mid,
  output logic [W-1:0] flag_out
);
  // First stage then output stage
  always_ff @(posedge clock) begin
    if (!rstn) begin
      flag_mid <= RST_VAL;
      flag_out <= RST_VAL;
    end else if (ce) begin
      flag_mid <= flag_in;
      flag_out <= flag_mid;
    end
  end
endmodule : mqfb_flag_pipe

// File: core/mqfb_flags.sv
// Per-queue status flags of a multi-queue FIFO
`timescale 1ns/1ps
module mqfb_flags #(
  parameter int NQ = mqfb_pkg::NQ_DEF,
  parameter int DEPTH = mqfb_pkg::DEPTH_DEF,
  parameter int OW = mqfb_pkg::OW_DEF
) (
  // Clock, reset, enable
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  // Configuration
  input wire logic default_offset_select,
  input wire logic [2:0] bus_mode,
  input wire logic offset_load,
  input wire logic [OW-1:0] prog_af_offset,
  input wire logic [OW-1:0] prog_ae_offset,
  // Write port
  input wire logic wr_sel_en,
  input wire logic [$clog2(NQ)-1:0] wr_sel_queue,
  input wire logic wr_en,
  input wire logic input_bit_35,
  input wire logic input_bit_34,
  // Read port
  input wire logic rd_sel_en,
  input wire logic [$clog2(NQ)-1:0] rd_sel_queue,
  input wire logic rd_en,
  input wire logic output_bit_34,
  // Write-side flags, active low
  output logic queue_full_flag_n,
  output logic almost_full_flag_n,
  output logic [NQ-1:0] almost_full_status_bus_n,
  // Read-side flags, active low
  output logic almost_empty_flag_n,
  output logic [NQ-1:0] almost_empty_status_bus_n,
  output logic packet_ready_flag_n
);
  localparam int QW = $clog2(NQ);
  localparam int CW = $clog2(DEPTH * 4 + 8) + OW + 1; // Room for offsets above the depth
  localparam int PW = CW;

  ////////////////////////////////////////////////////////////////////////////
  // Width and threshold arithmetic

  // Units of the narrower bus per 36-bit word
  function automatic int f_scale(input logic [2:0] mode);
    case (mode)
      mqfb_pkg::MODE_I36_O18, mqfb_pkg::MODE_I18_O36: f_scale = 2;
      mqfb_pkg::MODE_I36_O9, mqfb_pkg::MODE_I9_O36: f_scale = 4;
      default: f_scale = 1;
    endcase
  endfunction : f_scale

  // Output narrower than input
  function automatic logic f_out_narrow(input logic [2:0] mode);
    f_out_narrow = (mode == mqfb_pkg::MODE_I36_O18) || (mode == mqfb_pkg::MODE_I36_O9);
  endfunction : f_out_narrow

  // Units added by one write
  function automatic logic [CW-1:0] f_inc(input logic [2:0] mode);
    f_inc = f_out_narrow(mode) ? CW'(f_scale(mode)) : CW'(1);
  endfunction : f_inc

  // Units removed by one read
  function automatic logic [CW-1:0] f_dec(input logic [2:0] mode);
    f_dec = f_out_narrow(mode) ? CW'(1) : CW'(f_scale(mode));
  endfunction : f_dec

  // Full boundary in units
  function automatic logic [CW-1:0] f_full_thr(input logic [2:0] mode, input logic both);
    int base;
    base = DEPTH + ((!f_out_narrow(mode) && both) ? 1 : 0);
    f_full_thr = CW'(base * f_scale(mode));
  endfunction : f_full_thr

  // Almost-full boundary in units
  function automatic logic [CW-1:0] f_af_thr(input logic [2:0] mode, input logic both,
                                            input logic [OW-1:0] m);
    int base;
    logic plus_one;
    plus_one = !f_out_narrow(mode) && !((mode == mqfb_pkg::MODE_I36_O36) && !both);
    base = DEPTH + (plus_one ? 1 : 0) - int'(m);
    if (base < 1) base = 1;
    f_af_thr = CW'(base * f_scale(mode));
  endfunction : f_af_thr

  // Almost-empty release boundary in units
  function automatic logic [CW-1:0] f_ae_thr(input logic [2:0] mode, input logic both,
                                            input logic [OW-1:0] n);
    int base;
    base = int'(n) + 1 + ((!f_out_narrow(mode) && both) ? 1 : 0);
    f_ae_thr = CW'(base * f_scale(mode));
  endfunction : f_ae_thr

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic [OW-1:0] af_offset_ff;
  logic [OW-1:0] ae_offset_ff;
  logic [QW-1:0] wr_sel_ff;
  logic [QW-1:0] rd_sel_ff;
  logic [QW-1:0] rd_sel_d_ff;
  logic [CW-1:0] w_cnt_ff [NQ];
  logic [CW-1:0] r_cnt_ff [NQ];
  logic [PW-1:0] pkt_cnt_ff [NQ];
  logic [NQ-1:0] both_ff;
  logic [NQ-1:0] sop_seen_ff;
  logic [NQ-1:0] wr_d_ff;
  logic [NQ-1:0] rd_d_ff;
  logic [NQ-1:0] eop_d_ff;
  logic [CW-1:0] nxt_w_cnt [NQ];
  logic [NQ-1:0] wr_hit;
  logic [NQ-1:0] rd_hit;
  logic [NQ-1:0] eop_hit;
  logic [NQ-1:0] sop_rd_hit;
  logic [NQ-1:0] af_now_n;
  logic [NQ-1:0] ae_now_n;
  logic [NQ-1:0] pr_now_n;
  logic [NQ-1:0] af_mid_n;
  logic [NQ-1:0] ae_mid_n;
  logic [NQ-1:0] pr_mid_n;
  logic [QW-1:0] nxt_wr_sel;
  logic wr_ok;
  logic rd_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Offsets and queue selection

  // Strap sampled during reset, later load overrides
  always_ff @(posedge clock) begin
    if (!rstn) begin
      af_offset_ff <= default_offset_select ? mqfb_pkg::OFFSET_DEF_HIGH[OW-1:0]
                                            : mqfb_pkg::OFFSET_DEF_LOW[OW-1:0];
      ae_offset_ff <= default_offset_select ? mqfb_pkg::OFFSET_DEF_HIGH[OW-1:0]
                                            : mqfb_pkg::OFFSET_DEF_LOW[OW-1:0];
    end else if (ce && offset_load) begin
      af_offset_ff <= prog_af_offset;
      ae_offset_ff <= prog_ae_offset;
    end
  end

  assign nxt_wr_sel = wr_sel_en ? wr_sel_queue : wr_sel_ff;

  // Selected queues on each port
  always_ff @(posedge clock) begin
    if (!rstn) begin
      wr_sel_ff <= '0;
      rd_sel_ff <= '0;
      rd_sel_d_ff <= '0;
    end else if (ce) begin
      wr_sel_ff <= nxt_wr_sel;
      if (rd_sel_en) rd_sel_ff <= rd_sel_queue;
      rd_sel_d_ff <= rd_sel_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write and read acceptance

  // Writes stop at full, reads stop at empty
  assign wr_ok = wr_en && (w_cnt_ff[wr_sel_ff] < f_full_thr(bus_mode, both_ff[wr_sel_ff]));
  assign rd_ok = rd_en && (r_cnt_ff[rd_sel_ff] >= f_dec(bus_mode));

  // Per-queue event decode
  always_comb begin
    wr_hit = '0;
    rd_hit = '0;
    eop_hit = '0;
    sop_rd_hit = '0;
    if (wr_ok) begin
      wr_hit[wr_sel_ff] = 1'b1;
      eop_hit[wr_sel_ff] = input_bit_35 && (sop_seen_ff[wr_sel_ff] || input_bit_34);
    end
    if (rd_ok) begin
      rd_hit[rd_sel_ff] = 1'b1;
      sop_rd_hit[rd_sel_ff] = output_bit_34;
    end
  end

  // Skew window: each side sees the other's events one cycle late
  always_ff @(posedge clock) begin
    if (!rstn) begin
      wr_d_ff <= '0;
      rd_d_ff <= '0;
      eop_d_ff <= '0;
    end else if (ce) begin
      wr_d_ff <= wr_hit;
      rd_d_ff <= rd_hit;
      eop_d_ff <= eop_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Occupancy counts

  // Write-side view: own writes now, reads after the skew window
  always_comb begin
    for (int q = 0; q < NQ; q++) begin
      nxt_w_cnt[q] = w_cnt_ff[q];
      if (wr_hit[q]) nxt_w_cnt[q] = nxt_w_cnt[q] + f_inc(bus_mode);
      if (rd_d_ff[q]) nxt_w_cnt[q] = nxt_w_cnt[q] - f_dec(bus_mode);
    end
  end

  // Write-side count registers
  always_ff @(posedge clock) begin
    if (!rstn) begin
      for (int q = 0; q < NQ; q++) w_cnt_ff[q] <= '0;
    end else if (ce) begin
      for (int q = 0; q < NQ; q++) w_cnt_ff[q] <= nxt_w_cnt[q];
    end
  end

  // Read-side view: own reads now, writes after the skew window
  always_ff @(posedge clock) begin
    if (!rstn) begin
      for (int q = 0; q < NQ; q++) r_cnt_ff[q] <= '0;
    end else if (ce) begin
      for (int q = 0; q < NQ; q++) begin
        r_cnt_ff[q] <= r_cnt_ff[q] + (wr_d_ff[q] ? f_inc(bus_mode) : CW'(0))
                       - (rd_hit[q] ? f_dec(bus_mode) : CW'(0));
      end
    end
  end

  // Both-port selection caught on a queue's first word
  always_ff @(posedge clock) begin
    if (!rstn) begin
      both_ff <= '0;
    end else if (ce) begin
      for (int q = 0; q < NQ; q++) begin
        if (wr_hit[q] && (w_cnt_ff[q] == '0)) both_ff[q] <= (rd_sel_ff == QW'(q));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Packet tracking

  // Start marker remembered until its end marker
  always_ff @(posedge clock) begin
    if (!rstn) begin
      sop_seen_ff <= '0;
    end else if (ce) begin
      for (int q = 0; q < NQ; q++) begin
        if (wr_hit[q] && input_bit_35) sop_seen_ff[q] <= 1'b0;
        else if (wr_hit[q] && input_bit_34) sop_seen_ff[q] <= 1'b1;
      end
    end
  end

  // Complete packets per queue, a new packet and a counted read in one cycle leave it unchanged
  always_ff @(posedge clock) begin
    if (!rstn) begin
      for (int q = 0; q < NQ; q++) pkt_cnt_ff[q] <= '0;
    end else if (ce) begin
      for (int q = 0; q < NQ; q++) begin
        if (eop_d_ff[q] && !(sop_rd_hit[q] && pkt_cnt_ff[q] != '0)) begin
          pkt_cnt_ff[q] <= pkt_cnt_ff[q] + PW'(1);
        end else if (!eop_d_ff[q] && sop_rd_hit[q] && pkt_cnt_ff[q] != '0) begin
          pkt_cnt_ff[q] <= pkt_cnt_ff[q] - PW'(1);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Boundary compares for all queues at once

  always_comb begin
    for (int q = 0; q < NQ; q++) begin
      af_now_n[q] = w_cnt_ff[q] < f_af_thr(bus_mode, both_ff[q], af_offset_ff);
      ae_now_n[q] = r_cnt_ff[q] >= f_ae_thr(bus_mode, both_ff[q], ae_offset_ff);
      pr_now_n[q] = pkt_cnt_ff[q] == '0;
    end
  end

  // Almost-full bus: two stages after the count moves
  mqfb_flag_pipe #(
    .W(NQ),
    .RST_VAL({NQ{1'b1}})
  ) u_af_pipe (
    .clock(clock),
    .rstn(rstn),
    .ce(ce),
    .flag_in(af_now_n),
    .flag_mid(af_mid_n),
    .flag_out(almost_full_status_bus_n)
  );

  // Almost-empty bus: two stages after the count moves
  mqfb_flag_pipe #(
    .W(NQ),
    .RST_VAL({NQ{1'b0}})
  ) u_ae_pipe (
    .clock(clock),
    .rstn(rstn),
    .ce(ce),
    .flag_in(ae_now_n),
    .flag_mid(ae_mid_n),
    .flag_out(almost_empty_status_bus_n)
  );

  // Packet-ready: the output stage is taken per selected queue
  mqfb_flag_pipe #(
    .W(NQ),
    .RST_VAL({NQ{1'b1}})
  ) u_pr_pipe (
    .clock(clock),
    .rstn(rstn),
    .ce(ce),
    .flag_in(pr_now_n),
    .flag_mid(pr_mid_n),
    .flag_out()
  );

  ////////////////////////////////////////////////////////////////////////////
  // Active write-side flags

  // Full follows the selected queue on the filling write
  always_ff @(posedge clock) begin
    if (!rstn) begin
      queue_full_flag_n <= 1'b1;
    end else if (ce) begin
      queue_full_flag_n <= nxt_w_cnt[nxt_wr_sel] <
                           f_full_thr(bus_mode, both_ff[nxt_wr_sel]);
    end
  end

  // Almost-full of the selected write queue
  always_ff @(posedge clock) begin
    if (!rstn) begin
      almost_full_flag_n <= 1'b1;
    end else if (ce) begin
      almost_full_flag_n <= af_mid_n[wr_sel_ff];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Active read-side flags

  // Almost-empty and packet-ready of the selected read queue
  always_ff @(posedge clock) begin
    if (!rstn) begin
      almost_empty_flag_n <= 1'b0;
      packet_ready_flag_n <= 1'b1;
    end else if (ce) begin
      almost_empty_flag_n <= ae_mid_n[rd_sel_d_ff];
      packet_ready_flag_n <= pr_mid_n[rd_sel_d_ff];
    end
  end
endmodule : mqfb_flags

// File: core/mqfb_pkg.sv
// Shared constants for the multi-queue flag boundary logic
package mqfb_pkg;
  // Queue count, queue depth and offset width defaults
  localparam int NQ_DEF = 8;
  localparam int DEPTH_DEF = 1024;
  localparam int OW_DEF = 16;
  // Bus-width setups, shared by all queues
  localparam logic [2:0] MODE_I36_O36 = 3'h0;
  localparam logic [2:0] MODE_I36_O18 = 3'h1;
  localparam logic [2:0] MODE_I36_O9 = 3'h2;
  localparam logic [2:0] MODE_I18_O36 = 3'h3;
  localparam logic [2:0] MODE_I9_O36 = 3'h4;
  // Default offsets chosen by the default-select strap
  localparam logic [15:0] OFFSET_DEF_LOW = 16'h0008;
  localparam logic [15:0] OFFSET_DEF_HIGH = 16'h0080;
  // Flag pipeline depth and the one-cycle skew window
  localparam int FLAG_PIPE_STAGES = 2;
  localparam int SKEW_CYCLES = 1;
endpackage : mqfb_pkg

// File: dv/mqfb_flags_monitor.sv
// Timing checker for the queue flag outputs
`timescale 1ns/1ps
module mqfb_flags_monitor #(
  parameter int NQ = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Port strobes
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic rd_sel_en,
  input wire logic input_bit_35,
  input wire logic output_bit_34,
  // Flags
  input wire logic queue_full_flag_n,
  input wire logic [NQ-1:0] almost_full_status_bus_n,
  input wire logic almost_empty_flag_n,
  input wire logic packet_ready_flag_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////
  // Edges of full, almost-empty, packet-ready and almost-full bus line 0 trace back to their cause
  property p_full_fall;
    $fell(queue_full_flag_n) |-> $past(wr_en);
  endproperty
  a_full_fall: assert property (p_full_fall) else $error("full fell, no write");
  property p_full_rise;
    $rose(queue_full_flag_n) |-> $past(rd_en, 2);
  endproperty
  a_full_rise: assert property (p_full_rise) else $error("full rose, no read");
  property p_af_fall;
    $fell(almost_full_status_bus_n[0]) |-> $past(wr_en, 3);
  endproperty
  a_af_fall: assert property (p_af_fall) else $error("af line fell late");
  property p_af_rise;
    $rose(almost_full_status_bus_n[0]) |-> $past(rd_en, 4);
  endproperty
  a_af_rise: assert property (p_af_rise) else $error("af line rose late");
  property p_ae_fall;
    $fell(almost_empty_flag_n) |-> $past(rd_en, 3) || $past(rd_sel_en, 3);
  endproperty
  a_ae_fall: assert property (p_ae_fall) else $error("ae fell late");
  property p_ae_rise;
    $rose(almost_empty_flag_n) |-> $past(wr_en, 4) || $past(rd_sel_en, 3);
  endproperty
  a_ae_rise: assert property (p_ae_rise) else $error("ae rose late");
  property p_pr_fall;
    $fell(packet_ready_flag_n) |-> $past(wr_en, 4) && $past(input_bit_35, 4);
  endproperty
  a_pr_fall: assert property (p_pr_fall) else $error("ready fell late");
  property p_pr_rise;
    $rose(packet_ready_flag_n) |-> $past(rd_en, 3) && $past(output_bit_34, 3);
  endproperty
  a_pr_rise: assert property (p_pr_rise) else $error("ready rose late");
  // Main scenarios reached
  c_full: cover property ($fell(queue_full_flag_n));
  c_ae: cover property ($rose(almost_empty_flag_n));
  c_pr: cover property ($fell(packet_ready_flag_n));
endmodule : mqfb_flags_monitor

bind mqfb_flags mqfb_flags_monitor #(.NQ(NQ)) i_mqfb_flags_monitor (
  .clock(clock), .rstn(rstn), .wr_en(wr_en), .rd_en(rd_en), .rd_sel_en(rd_sel_en),
  .input_bit_35(input_bit_35), .output_bit_34(output_bit_34),
  .queue_full_flag_n(queue_full_flag_n), .almost_full_status_bus_n(almost_full_status_bus_n),
  .almost_empty_flag_n(almost_empty_flag_n), .packet_ready_flag_n(packet_ready_flag_n));

// File: dv/mqfb_partner.sv
// Writer and reader model on the two queue ports
`timescale 1ns/1ps
module mqfb_partner (
  // Clock
  input wire logic clock,
  // Write port
  output logic wr_sel_en,
  output logic [2:0] wr_sel_queue,
  output logic wr_en,
  output logic input_bit_35,
  output logic input_bit_34,
  // Read port
  output logic rd_sel_en,
  output logic [2:0] rd_sel_queue,
  output logic rd_en,
  output logic output_bit_34
);
  // Start markers of held words, per queue
  bit mq[8][$];
  int wq;
  int rq;
  initial begin
    {wr_sel_en, wr_sel_queue, wr_en, input_bit_35, input_bit_34} = '0;
    {rd_sel_en, rd_sel_queue, rd_en, output_bit_34} = '0;
    wq = 0;
    rq = 0;
  end
  // Forget contents, as a master reset does
  task clr;
    foreach (mq[i]) mq[i].delete();
    wq = 0;
    rq = 0;
  endtask : clr
  // Back-to-back writes; mk is {end, start}
  task wr(input int n, input logic [1:0] mk);
    repeat (n) begin
      @(posedge clock);
      wr_en <= 1'b1;
      {input_bit_35, input_bit_34} <= mk;
      mq[wq].push_back(mk[0]);
    end
    @(posedge clock);
    wr_en <= 1'b0;
    {input_bit_35, input_bit_34} <= ~mk;
  endtask : wr
  // Back-to-back reads; marker shown with its strobe
  task rd(input int n);
    repeat (n) begin
      @(posedge clock);
      rd_en <= 1'b1;
      output_bit_34 <= mq[rq].pop_front();
    end
    @(posedge clock);
    rd_en <= 1'b0;
    output_bit_34 <= ~output_bit_34;
  endtask : rd
  // Queue switch, then wait before trusting flags
  task sel(input logic wside, input logic [2:0] q);
    @(posedge clock);
    if (wside) begin
      wr_sel_en <= 1'b1;
      wr_sel_queue <= q;
      wq = q;
    end else begin
      rd_sel_en <= 1'b1;
      rd_sel_queue <= q;
      rq = q;
    end
    @(posedge clock);
    wr_sel_en <= 1'b0;
    rd_sel_en <= 1'b0;
    repeat (2) @(posedge clock);
  endtask : sel
endmodule : mqfb_partner

// File: dv/tb_mqfb_flags.sv
// Self-checking bench for the queue flag block
`timescale 1ns/1ps
module tb_mqfb_flags;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic dos = 1'b0;
  logic ce = 1'b1;
  logic offset_load = 1'b0;
  logic [2:0] bus_mode = mqfb_pkg::MODE_I36_O36;
  logic [15:0] af_off = 16'h0004;
  logic [15:0] ae_off = 16'h0004;
  logic wr_sel_en, wr_en, ib35, ib34, rd_sel_en, rd_en, ob34;
  logic [2:0] wr_sel_queue, rd_sel_queue;
  logic full_n, af_n, ae_n, pr_n;
  logic [7:0] af_bus, ae_bus;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  always #12.5 clock = ~clock;
  ////////////////////////////////////////
  // Design with a short queue depth
  mqfb_flags #(.NQ(8), .DEPTH(16), .OW(16)) i_mqfb_flags (
    .clock(clock), .rstn(rstn), .ce(ce), .default_offset_select(dos),
    .bus_mode(bus_mode), .offset_load(offset_load),
    .prog_af_offset(af_off), .prog_ae_offset(ae_off),
    .wr_sel_en(wr_sel_en), .wr_sel_queue(wr_sel_queue), .wr_en(wr_en),
    .input_bit_35(ib35), .input_bit_34(ib34), .rd_sel_en(rd_sel_en),
    .rd_sel_queue(rd_sel_queue), .rd_en(rd_en), .output_bit_34(ob34),
    .queue_full_flag_n(full_n), .almost_full_flag_n(af_n),
    .almost_full_status_bus_n(af_bus), .almost_empty_flag_n(ae_n),
    .almost_empty_status_bus_n(ae_bus), .packet_ready_flag_n(pr_n));
  mqfb_partner i_mqfb_partner (
    .clock(clock), .wr_sel_en(wr_sel_en), .wr_sel_queue(wr_sel_queue),
    .wr_en(wr_en), .input_bit_35(ib35), .input_bit_34(ib34),
    .rd_sel_en(rd_sel_en), .rd_sel_queue(rd_sel_queue), .rd_en(rd_en),
    .output_bit_34(ob34));
  ////////////////////////////////////////
  // Verdict and end of run
  task close_out;
    if (fail_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out
  // Compare one result
  task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Let flags settle, then compare {af, ae, full, ready}
  task look(input logic [7:0] exp);
    repeat (5) @(posedge clock);
    @(negedge clock);
    chk({4'h0, af_n, ae_n, full_n, pr_n}, exp);
  endtask : look
  // Synchronous reset held eight cycles
  task do_reset(input logic sel_hi, input logic [2:0] md);
    i_mqfb_partner.clr();
    @(posedge clock);
    rstn <= 1'b0;
    dos <= sel_hi;
    bus_mode <= md;
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
  endtask : do_reset
  // Program both offsets for all queues
  task load_offsets(input logic [15:0] m, input logic [15:0] n);
    @(posedge clock);
    af_off <= m;
    ae_off <= n;
    offset_load <= 1'b1;
    @(posedge clock);
    offset_load <= 1'b0;
  endtask : load_offsets
  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      close_out();
    end
  end
  ////////////////////////////////////////
  // Offsets 8, depth 16, both ports on queue 0
  initial begin
    do_reset(1'b0, mqfb_pkg::MODE_I36_O36);
    look(8'h0b);
    i_mqfb_partner.wr(8, 2'b00);
    look(8'h0b);
    i_mqfb_partner.wr(1, 2'b00);
    look(8'h03);
    chk(af_bus, 8'hfe);
    i_mqfb_partner.wr(1, 2'b00);
    look(8'h07);
    chk(ae_bus, 8'h01);
    i_mqfb_partner.wr(7, 2'b00);
    look(8'h05);
    i_mqfb_partner.rd(1);
    look(8'h07);
    i_mqfb_partner.rd(8);
    look(8'h0b);
    chk(af_bus, 8'hff);
    chk(ae_bus, 8'h00);
    i_mqfb_partner.wr(1, 2'b01);
    i_mqfb_partner.wr(1, 2'b10);
    look(8'h06);
    i_mqfb_partner.rd(8);
    look(8'h0a);
    i_mqfb_partner.rd(1);
    look(8'h0b);
    i_mqfb_partner.rd(1);
    // Queue 1 filled from the write port only
    i_mqfb_partner.sel(1'b1, 3'h1);
    i_mqfb_partner.wr(8, 2'b00);
    look(8'h03);
    chk(af_bus, 8'hfd);
    chk(ae_bus, 8'h00);
    i_mqfb_partner.wr(1, 2'b00);
    look(8'h03);
    chk(ae_bus, 8'h02);
    i_mqfb_partner.sel(1'b0, 3'h1);
    look(8'h07);
    // Strap high: offsets 128
    do_reset(1'b1, mqfb_pkg::MODE_I36_O36);
    i_mqfb_partner.wr(1, 2'b00);
    look(8'h03);
    chk(ae_bus, 8'h00);
    // Half-width input, programmed offsets, clock enable held low
    do_reset(1'b0, mqfb_pkg::MODE_I18_O36);
    load_offsets(16'h0002, 16'h0001);
    @(posedge clock);
    ce <= 1'b0;
    i_mqfb_partner.wr(4, 2'b00);
    ce <= 1'b1;
    look(8'h0b);
    i_mqfb_partner.wr(5, 2'b00);
    look(8'h0b);
    i_mqfb_partner.wr(1, 2'b00);
    look(8'h0f);
    i_mqfb_partner.wr(23, 2'b00);
    look(8'h0f);
    i_mqfb_partner.wr(1, 2'b00);
    look(8'h07);
    chk(af_bus, 8'hfe);
    i_mqfb_partner.wr(3, 2'b00);
    look(8'h07);
    i_mqfb_partner.wr(2, 2'b00);
    look(8'h05);
    i_mqfb_partner.rd(2);
    look(8'h07);
    i_mqfb_partner.rd(1);
    look(8'h0f);
    chk(af_bus, 8'hff);
    // Quarter-width output, strap high offsets beyond the depth
    do_reset(1'b1, mqfb_pkg::MODE_I36_O9);
    i_mqfb_partner.wr(16, 2'b00);
    look(8'h01);
    chk(ae_bus, 8'h00);
    i_mqfb_partner.rd(4);
    look(8'h03);
    close_out();
  end
endmodule : tb_mqfb_flags
